// [fault_irq_pkg.sv]
// register map, field positions and reset values for the fault status block
// assumes a byte-wide register port driven by the serial configuration logic
package fault_irq_pkg;
    localparam int          DATA_W            = 8;
    localparam int          ADDR_W            = 8;
    localparam int          NUM_INPUTS        = 4;
    localparam int          NUM_UPPER         = 2;
    localparam int          GPIO_W            = 8;
    localparam int          SEL_W             = 3;
    localparam logic [7:0]  INPUT_STATUS_ADDR = 8'h02;
    localparam logic [7:0]  LOOP_STATUS_ADDR  = 8'h03;
    localparam logic [7:0]  INPUT_ENABLE_ADDR = 8'h04;
    localparam logic [7:0]  LOOP_ENABLE_ADDR  = 8'h05;
    localparam logic [7:0]  UPPER_FAULT_ADDR  = 8'h06;
    localparam logic [7:0]  SIGNAL_SEL_ADDR   = 8'h40;
    localparam logic [7:0]  INPUT_ENABLE_RST  = 8'h00;
    localparam logic [7:0]  LOOP_ENABLE_RST   = 8'h00;
    localparam logic [7:0]  UPPER_FAULT_RST   = 8'h00;
    localparam logic [7:0]  SIGNAL_SEL_RST    = 8'h00;
    localparam int          HOLDOVER_BIT      = 0;
    localparam int          UNLOCK_BIT        = 1;
    localparam int          SIGNAL_ABSENT_BIT = 0;
    localparam int          PERIOD_FAULT_BIT  = 1;
    localparam int          RATE_FAULT_BIT    = 2;
    localparam int          TIMER_BIT         = 3;
    localparam int          UPPER_STRIDE      = 4;
    localparam int          SEL_HI_POS        = 4;
endpackage

// [sticky_bits.sv]
// a row of sticky flags: set pulses win over a clear strobe in the same cycle
// assumes set and clear are synchronous to clock
`timescale 1ns/1ps
module sticky_bits #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // events
    input  wire logic [W-1:0] setBits,
    input  wire logic [W-1:0] clearBits,
    // state
    output logic      [W-1:0] flags
);
    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // set beats clear so an event in the clearing cycle is kept
            assign flags_d[i] = setBits[i] | (flags_q[i] & ~clearBits[i]);
        end
    endgenerate

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    assign flags = flags_q;
endmodule

// [reference_fault_irq_status.sv]
// enables, sticky fault status and interrupt request for the reference inputs
// assumes a byte-wide register port already decoded from the serial interface
// Notes on behaviour
// R1: input enable gates interrupt and status recording
// R2: holdover enable gates its interrupt and status
// R3: unlock enable gates its interrupt and status
// R4: selected pin high sets sticky signal-absent bit; the code sets it only when the selected level rises
// R5: signal-absent source selectable from any pin
// R6: period monitor fault sets sticky bit unmasked
// R7: coarse or precise rate fault sets sticky
// R8: host separates rate faults by masking monitors
// R9: guard soak timer expiry sets sticky bit
// R10: status set only when enabled; raises request
// R11: sticky bits hold until host writes one
`timescale 1ns/1ps
module reference_fault_irq_status
    import fault_irq_pkg::*;
#(
    parameter int INPUTS = fault_irq_pkg::NUM_INPUTS,
    parameter int PINS   = fault_irq_pkg::GPIO_W
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // register port
    input  wire logic [fault_irq_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [fault_irq_pkg::DATA_W-1:0] regWrData,
    input  wire logic                            regWrite,
    input  wire logic                            regRead,
    output logic      [fault_irq_pkg::DATA_W-1:0] regRdData,
    // reference and loop monitors
    input  wire logic [INPUTS-1:0]               inputFault,
    input  wire logic                            holdoverEvent,
    input  wire logic                            unlockEvent,
    input  wire logic [1:0]                      periodFault,
    input  wire logic [1:0]                      coarseRateFault,
    input  wire logic [1:0]                      preciseRateFault,
    input  wire logic [1:0]                      timerExpired,
    // general-purpose pins
    input  wire logic [PINS-1:0]                 gpioIn,
    // interrupt request
    output logic                                 irqRequest
);
    import fault_irq_pkg::*;

    // ************************************************************
    // register decode
    // ************************************************************
    wire selInStatus = (regAddr == INPUT_STATUS_ADDR);
    wire selLpStatus = (regAddr == LOOP_STATUS_ADDR);
    wire selInEnable = (regAddr == INPUT_ENABLE_ADDR);
    wire selLpEnable = (regAddr == LOOP_ENABLE_ADDR);
    wire selUpper    = (regAddr == UPPER_FAULT_ADDR);
    wire selSignal   = (regAddr == SIGNAL_SEL_ADDR);

    logic [DATA_W-1:0] inputEnable_q;
    logic [DATA_W-1:0] loopEnable_q;
    logic [DATA_W-1:0] signalSel_q;
    logic [DATA_W-1:0] regRdData_q;
    logic [DATA_W-1:0] regRdData_d;
    logic [1:0]        pinLevel_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            inputEnable_q <= INPUT_ENABLE_RST;
            loopEnable_q  <= LOOP_ENABLE_RST;
            signalSel_q   <= SIGNAL_SEL_RST;
        end
        else if (regWrite)
        begin
            // reserved enable bits are kept at zero
            if (selInEnable)
                inputEnable_q <= {4'h0, regWrData[3:0]};
            if (selLpEnable)
                loopEnable_q <= {6'h00, regWrData[1:0]};
            // the pin selection is stored whole; its spare bits read back as written
            if (selSignal)
                signalSel_q <= regWrData;
        end
    end

    // ************************************************************
    // signal-absent pin routing
    // ************************************************************
    // pin number per upper input: low nibble for input two, high nibble for three
    wire [SEL_W-1:0] pinSelTwo   = signalSel_q[SEL_W-1:0];
    wire [SEL_W-1:0] pinSelThree = signalSel_q[SEL_HI_POS+SEL_W-1:SEL_HI_POS];
    // a selection past the last pin reads as low instead of unknown
    wire             pinTwoOk    = (int'(pinSelTwo) < PINS);
    wire             pinThreeOk  = (int'(pinSelThree) < PINS);
    wire [1:0]       pinLevel    = {pinThreeOk && gpioIn[pinSelThree],
                                    pinTwoOk && gpioIn[pinSelTwo]}; // see R5
    // a rising level sets the flag; a held level does not keep re-setting it
    // moving the selection onto a pin that is already high counts as a rise
    wire [1:0]       pinRise     = pinLevel & ~pinLevel_q; // see R4

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            // reset high so a pin already high at release sets nothing
            pinLevel_q <= 2'h3;
        else
            pinLevel_q <= pinLevel;
    end

    // ************************************************************
    // sticky status rows
    // ************************************************************
    logic [DATA_W-1:0] inSet;
    logic [DATA_W-1:0] lpSet;
    logic [DATA_W-1:0] upSet;
    logic [DATA_W-1:0] inFlags;
    logic [DATA_W-1:0] lpFlags;
    logic [DATA_W-1:0] upFlags;

    // status registers only ever clear from the port; they are never loaded
    wire wrInStatus = regWrite && selInStatus;
    wire wrLpStatus = regWrite && selLpStatus;
    wire wrUpper    = regWrite && selUpper;

    // write one to clear; a bit written as zero is left alone
    wire [DATA_W-1:0] inClear = wrInStatus ? regWrData : 8'h00; // see R11
    wire [DATA_W-1:0] lpClear = wrLpStatus ? regWrData : 8'h00; // see R11
    wire [DATA_W-1:0] upClear = wrUpper ? regWrData : 8'h00;    // see R11

    // ************************************************************
    // enable gating of the recorded events
    // ************************************************************
    // a masked event is dropped here, so it neither records nor requests
    genvar k;
    generate
        for (k = 0; k < DATA_W; k++)
        begin : g_inSet
            if (k < INPUTS)
            begin : g_used
                assign inSet[k] = inputFault[k] & inputEnable_q[k]; // see R1, R10
            end
            else
            begin : g_spare
                assign inSet[k] = 1'b0;
            end
        end
    endgenerate

    wire holdoverSet = holdoverEvent & loopEnable_q[HOLDOVER_BIT]; // see R2
    wire unlockSet   = unlockEvent & loopEnable_q[UNLOCK_BIT];     // see R3
    assign lpSet = {6'h00, unlockSet, holdoverSet};

    genvar r;
    generate
        for (r = 0; r < NUM_UPPER; r++)
        begin : g_upper
            // no enable gates these bits
            assign upSet[r*UPPER_STRIDE+SIGNAL_ABSENT_BIT] = pinRise[r];          // see R4
            assign upSet[r*UPPER_STRIDE+PERIOD_FAULT_BIT]  = periodFault[r];      // see R6
            assign upSet[r*UPPER_STRIDE+RATE_FAULT_BIT]    =
                coarseRateFault[r] | preciseRateFault[r];                          // see R7
            assign upSet[r*UPPER_STRIDE+TIMER_BIT]         = timerExpired[r];     // see R9
        end
    endgenerate

    sticky_bits #(.W(DATA_W)) u_inStatus
    (
        .clock     (clock),
        .rst       (rst),
        .setBits   (inSet),
        .clearBits (inClear),
        .flags     (inFlags)
    );

    sticky_bits #(.W(DATA_W)) u_lpStatus
    (
        .clock     (clock),
        .rst       (rst),
        .setBits   (lpSet),
        .clearBits (lpClear),
        .flags     (lpFlags)
    );

    sticky_bits #(.W(DATA_W)) u_upStatus
    (
        .clock     (clock),
        .rst       (rst),
        .setBits   (upSet),
        .clearBits (upClear),
        .flags     (upFlags)
    );

    // ************************************************************
    // read-back and interrupt
    // ************************************************************
    always_comb
    begin
        if (selInStatus)
            regRdData_d = inFlags;
        else if (selLpStatus)
            regRdData_d = lpFlags;
        else if (selInEnable)
            regRdData_d = inputEnable_q;
        else if (selLpEnable)
            regRdData_d = loopEnable_q;
        else if (selUpper)
            regRdData_d = upFlags;
        else if (selSignal)
            regRdData_d = signalSel_q;
        // unmapped addresses read as zero
        else
            regRdData_d = 8'h00;
    end

    // a read latches the byte once; it then stands until the next read
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            regRdData_q <= 8'h00;
        else if (regRead)
            regRdData_q <= regRdData_d;
    end

    // only the enabled, recorded events drive the request; monitor bits do not
    // the monitor row has no enable, so it is kept off the request
    assign irqRequest = (|inFlags) | (|lpFlags); // see R10
    assign regRdData  = regRdData_q;
endmodule

// [fault_host.sv]
// host model driving the byte-wide register port of the fault block
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ps
module fault_host
    import fault_irq_pkg::*;
(
    // clock
    input  wire logic                             clock,
    // register port
    output logic      [fault_irq_pkg::ADDR_W-1:0] regAddr,
    output logic      [fault_irq_pkg::DATA_W-1:0] regWrData,
    output logic                                  regWrite,
    output logic                                  regRead,
    input  wire logic [fault_irq_pkg::DATA_W-1:0] regRdData
);
    initial
    begin
        regAddr = '0;
        regWrData = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // released data turns to its inverse so a stale byte is never reused
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        regWrData = ~d;
    endtask
    task automatic readReg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        d = regRdData;
    endtask
endmodule

// [fault_irq_properties.sv]
// port checks for the fault status block
// assumes a bind onto every instance of the block
`timescale 1ns/1ps
module fault_irq_properties
    import fault_irq_pkg::*;
#(
    parameter int INPUTS = 4
) (
    // clock, reset and register port
    input wire logic                             clock,
    input wire logic                             rst,
    input wire logic [fault_irq_pkg::ADDR_W-1:0] regAddr,
    input wire logic [fault_irq_pkg::DATA_W-1:0] regWrData,
    input wire logic                             regWrite,
    input wire logic                             regRead,
    input wire logic [fault_irq_pkg::DATA_W-1:0] regRdData,
    // monitors and request
    input wire logic [INPUTS-1:0]                inputFault,
    input wire logic                             holdoverEvent,
    input wire logic                             unlockEvent,
    input wire logic [1:0]                       timerExpired,
    input wire logic                             irqRequest
);
    logic [INPUTS-1:0] inEnable_q;
    logic [1:0]        loopEnable_q;
    wire  logic        setCause;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // enables are mirrored here since the checker cannot see inside
    always_ff @(posedge clock or posedge rst)
        if (rst)
        begin
            inEnable_q <= '0;
            loopEnable_q <= '0;
        end
        else if (regWrite && regAddr == INPUT_ENABLE_ADDR)
            inEnable_q <= regWrData[INPUTS-1:0];
        else if (regWrite && regAddr == LOOP_ENABLE_ADDR)
            loopEnable_q <= regWrData[1:0];
    assign setCause = |(inputFault & inEnable_q) | holdoverEvent & loopEnable_q[0]
        | unlockEvent & loopEnable_q[1];
    property p_inputSets; |(inputFault & inEnable_q) |=> irqRequest; endproperty
    a_inputSets: assert property (p_inputSets) else $error("input fault lost");
    property p_holdSets; holdoverEvent && loopEnable_q[0] |=> irqRequest; endproperty
    a_holdSets: assert property (p_holdSets) else $error("holdover lost");
    property p_unlockSets; unlockEvent && loopEnable_q[1] |=> irqRequest; endproperty
    a_unlockSets: assert property (p_unlockSets) else $error("unlock lost");
    property p_irqCause; $rose(irqRequest) |-> $past(setCause); endproperty
    a_irqCause: assert property (p_irqCause) else $error("request without cause");
    property p_quiet; !irqRequest && !setCause |=> !irqRequest; endproperty
    a_quiet: assert property (p_quiet) else $error("masked event raised request");
    property p_irqHolds; irqRequest && !regWrite |=> irqRequest; endproperty
    a_irqHolds: assert property (p_irqHolds) else $error("request dropped");
    property p_enableRead;
        regRead && regAddr == INPUT_ENABLE_ADDR && !regWrite |=> regRdData == {4'h0, inEnable_q};
    endproperty
    a_enableRead: assert property (p_enableRead) else $error("enable readback");
    property p_timerSticky;
        timerExpired[1] ##1 regRead && regAddr == UPPER_FAULT_ADDR && !regWrite |=> regRdData[7];
    endproperty
    a_timerSticky: assert property (p_timerSticky) else $error("timer flag");
endmodule
bind reference_fault_irq_status fault_irq_properties #(.INPUTS(INPUTS)) chk
(
    .clock         (clock),
    .rst           (rst),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWrite      (regWrite),
    .regRead       (regRead),
    .regRdData     (regRdData),
    .inputFault    (inputFault),
    .holdoverEvent (holdoverEvent),
    .unlockEvent   (unlockEvent),
    .timerExpired  (timerExpired),
    .irqRequest    (irqRequest)
);

// [reference_fault_irq_status_tb.sv]
// self-checking bench for the fault status block
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
module reference_fault_irq_status_tb;
    import fault_irq_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [13:0] mon = '0;
    logic [7:0]  gpio = '0;
    logic [7:0]  rd, regAddr, regWrData, regRdData;
    logic        regWrite, regRead, irqRequest;
    int          bad_count = 0;
    int          checked = 0;
    always #10 clock = ~clock;
    fault_host host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
    reference_fault_irq_status uut (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .inputFault(mon[13:10]), .holdoverEvent(mon[9]),
        .unlockEvent(mon[8]), .periodFault(mon[7:6]), .coarseRateFault(mon[5:4]),
        .preciseRateFault(mon[3:2]), .timerExpired(mon[1:0]), .gpioIn(gpio),
        .irqRequest(irqRequest));
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // monitors stay high across the read so the flag is set one edge before it
    task automatic probe(input logic [13:0] v, input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        mon = v;
        host.readReg(a, rd);
        mon = '0;
        check("status", rd, e);
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (int a = 2; a <= 6; a++)
            probe('0, 8'(a), 8'h00);
        probe(14'h3F00, INPUT_STATUS_ADDR, 8'h00);
        probe(14'h0000, LOOP_STATUS_ADDR, 8'h00);
        check("irq", {7'h0, irqRequest}, 8'h00);
        host.writeReg(INPUT_ENABLE_ADDR, 8'hFF);
        probe('0, INPUT_ENABLE_ADDR, 8'h0F);
        for (int i = 0; i < 4; i++)
        begin
            probe(14'(1) << (10 + i), INPUT_STATUS_ADDR, 8'(1) << i);
            check("irq", {7'h0, irqRequest}, 8'h01);
            probe('0, INPUT_STATUS_ADDR, 8'(1) << i);
            host.writeReg(INPUT_STATUS_ADDR, 8'(1) << i);
            check("irq", {7'h0, irqRequest}, 8'h00);
        end
        // a fault still high during the clearing write keeps its flag
        mon = 14'h0400;
        host.writeReg(INPUT_STATUS_ADDR, 8'h01);
        mon = '0;
        probe('0, INPUT_STATUS_ADDR, 8'h01);
        host.writeReg(INPUT_STATUS_ADDR, 8'h01);
        check("irq", {7'h0, irqRequest}, 8'h00);
        host.writeReg(LOOP_ENABLE_ADDR, 8'hFF);
        probe('0, LOOP_ENABLE_ADDR, 8'h03);
        probe(14'h0200, LOOP_STATUS_ADDR, 8'h01);
        check("irq", {7'h0, irqRequest}, 8'h01);
        probe(14'h0100, LOOP_STATUS_ADDR, 8'h03);
        host.writeReg(LOOP_STATUS_ADDR, 8'h03);
        probe('0, LOOP_STATUS_ADDR, 8'h00);
        probe(14'h00C0, UPPER_FAULT_ADDR, 8'h22);
        probe(14'h0010, UPPER_FAULT_ADDR, 8'h26);
        probe(14'h0008, UPPER_FAULT_ADDR, 8'h66);
        probe(14'h0003, UPPER_FAULT_ADDR, 8'hEE);
        check("irq", {7'h0, irqRequest}, 8'h00);
        host.writeReg(UPPER_FAULT_ADDR, 8'hFF);
        host.writeReg(SIGNAL_SEL_ADDR, 8'h53);
        gpio = 8'h09;
        probe('0, UPPER_FAULT_ADDR, 8'h01);
        gpio = 8'h21;
        probe('0, UPPER_FAULT_ADDR, 8'h11);
        host.writeReg(UPPER_FAULT_ADDR, 8'h11);
        probe('0, UPPER_FAULT_ADDR, 8'h00);
        host.writeReg(8'h10, 8'hFF);
        probe('0, 8'h10, 8'h00);
        probe('0, INPUT_ENABLE_ADDR, 8'h0F);
        stop_test();
    end
endmodule
